// ===== uart_regs_consts.vh
// register offsets, field positions and reset values of the uart register map
`ifndef UART_REGS_CONSTS_VH
`define UART_REGS_CONSTS_VH
`define A_DATA 4'h0
`define A_IER 4'h1
`define A_ISR 4'h2
`define A_LCR 4'h3
`define A_MCR 4'h4
`define A_LSR 4'h5
`define A_MSR 4'h6
`define A_SPR 4'h7
`define A_DLL 4'h0
`define A_DLM 4'h1
`define A_DLD 4'h2
`define A_EFR 4'h2
`define A_RESUME_CHAR_FIRST 4'h4
`define A_RESUME_CHAR_SECOND 4'h5
`define A_PAUSE_CHAR_FIRST 4'h6
`define A_PAUSE_CHAR_SECOND 4'h7
`define A_GPIO_DIRECTION 4'h0a
`define A_IOLVL 4'h0b
`define A_IOMSK 4'h0c
`define A_RSVD 4'h0d
`define A_IOCTL 4'h0e
`define A_EXTRA_FEATURE_CTRL 4'h0f
`define LCR_BANK_ENH 8'hbf
`define LCR_DIV_BIT 7
`define EFR_ENH_BIT 4
`define FCR_EN_BIT 0
`define FCR_RXRST_BIT 1
`define IOCTL_LATCH_BIT 0
`define IOCTL_SRST_BIT 3
`define EXTRA_FEATURE_CTRL_RXDIS_BIT 1
`define EXTRA_FEATURE_CTRL_TXDIS_BIT 2
`define BASE_MASK 8'h0f
`define ENH_IER_MASK 8'hf0
`define ENH_FCR_MASK 8'h30
`define ENH_MCR_MASK 8'he0
`define FCR_SAVE_MASK 8'hf9
`define IOCTL_MASK 8'h01
`define EXTRA_FEATURE_CTRL_MASK 8'h06
`define ISR_NONE 6'h01
`define ISR_LINE 6'h06
`define ISR_RXDATA 6'h04
`define ISR_TXRDY 6'h02
`define ISR_MODEM 6'h00
`define REG_RST 8'h00
`define LCR_RST 8'h03
`define TRIG_L0 4'd1
`define TRIG_L1 4'd2
`define TRIG_L2 4'd4
`define TRIG_L3 4'd6
`endif

// ===== uart_regs.v
// uart register map, receive fifo and line and interrupt status
`timescale 1ns/1ps
`include "uart_regs_consts.vh"

module rx_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire flush_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0] count_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg room_r;
  reg empty_r;
  wire push;
  wire pop;
  wire [AW:0] cnt_nxt;
  assign push = in_valid_in & room_r;
  assign pop = out_ready_in & ~empty_r;
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_out = room_r;
  assign out_valid_out = ~empty_r;
  assign out_data_out = mem[rp_r];
  assign count_out = cnt_r;
  always @(posedge clk_in)
  begin
    if (push)
      mem[wp_r] <= in_data_in;
  end
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      room_r <= 1'b1;
      empty_r <= 1'b1;
    end
    else if (flush_in)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      room_r <= 1'b1;
      empty_r <= 1'b1;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      room_r <= (cnt_nxt != DEPTH);
      empty_r <= (cnt_nxt == {(AW+1){1'b0}});
    end
  end
endmodule

module uart_regs #(
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter GPIO_W = 4
) (
  input wire clk_in,
  input wire rstn_in,
  input wire [3:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  input wire rx_char_valid_in,
  input wire [7:0] rx_char_in,
  input wire [2:0] rx_err_in,
  output wire rx_ready_out,
  input wire tx_hold_empty_in,
  input wire tx_shift_empty_in,
  output reg tx_wr_out,
  output reg [7:0] tx_data_out,
  input wire [7:0] modem_state_in,
  input wire [GPIO_W-1:0] gpio_pin_in,
  output reg [GPIO_W-1:0] gpio_out,
  output reg [GPIO_W-1:0] gpio_oe_out,
  output reg irq_n_out,
  output reg [15:0] divisor_out,
  output reg [5:0] fraction_out,
  output reg rx_disable_out,
  output reg tx_disable_out,
  output reg soft_reset_out
);
  reg [1:0] rst_sync_r;
  wire rst_n;
  reg [GPIO_W-1:0] gpio_s1_r;
  reg [GPIO_W-1:0] gpio_s2_r;
  reg [GPIO_W-1:0] gpio_input_latch;
  reg [7:0] irq_mask_reg;
  reg [7:0] fifo_setup_reg;
  reg [7:0] line_format_reg;
  reg [7:0] modem_ctrl_reg;
  reg [7:0] scratch_r;
  reg [7:0] divisor_low_byte;
  reg [7:0] divisor_high_byte;
  reg [7:0] fraction_and_sampling;
  reg [7:0] enhanced_feature_ctrl;
  reg [7:0] resume_char_first;
  reg [7:0] resume_char_second;
  reg [7:0] pause_char_first;
  reg [7:0] pause_char_second;
  reg [7:0] gpio_direction;
  reg [7:0] gpio_level;
  reg [7:0] gpio_irq_mask;
  reg [7:0] io_and_soft_reset_ctrl;
  reg [7:0] extra_feature_ctrl;
  reg overrun_r;
  reg [AW:0] err_cnt_r;
  reg [7:0] rdata_nxt;
  reg [5:0] isr_code;
  reg [3:0] trig;
  wire enh;
  wire bank_enh;
  wire bank_div;
  wire wr_norm;
  wire rd_norm;
  wire fifo_en;
  wire [10:0] head;
  wire head_valid;
  wire [AW:0] rx_cnt;
  wire pop;
  wire push_ok;
  wire flush;
  wire [7:0] line_state_reg;
  wire [7:0] irq_source_reg;
  wire [GPIO_W-1:0] gpio_view;
  wire rx_hit;

  // release of the async reset is retimed; soft reset clears the fifo, status and control registers but not scratch, divisor, resume and pause characters or gpio
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_s1_r <= {GPIO_W{1'b0}};
      gpio_s2_r <= {GPIO_W{1'b0}};
    end
    else
    begin
      gpio_s1_r <= gpio_pin_in;
      gpio_s2_r <= gpio_s1_r;
    end
  end

  assign enh = enhanced_feature_ctrl[`EFR_ENH_BIT];
  assign bank_enh = (line_format_reg == `LCR_BANK_ENH);
  assign bank_div = line_format_reg[`LCR_DIV_BIT] & ~bank_enh;
  assign wr_norm = reg_wr_in & ~bank_enh & ~bank_div;
  assign rd_norm = reg_rd_in & ~bank_enh & ~bank_div;
  assign fifo_en = fifo_setup_reg[`FCR_EN_BIT];
  assign pop = rd_norm & (reg_addr_in == `A_DATA);
  assign flush = soft_reset_out | (reg_wr_in & ~bank_enh & ~bank_div
    & (reg_addr_in == `A_ISR) & reg_wdata_in[`FCR_EN_BIT]
    & reg_wdata_in[`FCR_RXRST_BIT]);
  assign push_ok = rx_char_valid_in & rx_ready_out & ~rx_disable_out;

  rx_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .flush_in(flush),
    .in_valid_in(rx_char_valid_in & ~rx_disable_out),
    .in_ready_out(rx_ready_out),
    .in_data_in({rx_err_in, rx_char_in}),
    .out_valid_out(head_valid),
    .out_ready_in(pop),
    .out_data_out(head),
    .count_out(rx_cnt)
  );

  always @*
  begin
    case (fifo_setup_reg[7:6])
      2'd0: trig = `TRIG_L0;
      2'd1: trig = `TRIG_L1;
      2'd2: trig = `TRIG_L2;
      default: trig = `TRIG_L3;
    endcase
  end

  // without fifos one character is enough to raise the rx source
  assign rx_hit = fifo_en ? ({1'b0, rx_cnt} >= {1'b0, trig}) : head_valid;

  assign line_state_reg = {
    err_cnt_r != {(AW+1){1'b0}},
    tx_hold_empty_in & tx_shift_empty_in,
    tx_hold_empty_in,
    head_valid ? head[10:8] : 3'b000,
    overrun_r,
    head_valid};

  // priority: line error, rx data, tx ready, modem; all cleared gives polling
  always @*
  begin
    if (irq_mask_reg[2] & (line_state_reg[1] | line_state_reg[7]))
      isr_code = `ISR_LINE;
    else if (irq_mask_reg[0] & rx_hit)
      isr_code = `ISR_RXDATA;
    else if (irq_mask_reg[1] & tx_hold_empty_in)
      isr_code = `ISR_TXRDY;
    else if (irq_mask_reg[3] & (modem_state_in[3:0] != 4'h0))
      isr_code = `ISR_MODEM;
    else
      isr_code = `ISR_NONE;
  end
  assign irq_source_reg = {fifo_en, fifo_en, isr_code};

  assign gpio_view = io_and_soft_reset_ctrl[`IOCTL_LATCH_BIT]
    ? gpio_input_latch : gpio_s2_r;

  always @*
  begin
    rdata_nxt = `REG_RST;
    if (reg_addr_in == `A_GPIO_DIRECTION)
      rdata_nxt = gpio_direction;
    else if (reg_addr_in == `A_IOLVL)
      rdata_nxt = {{(8-GPIO_W){1'b0}}, (gpio_view & ~gpio_direction[GPIO_W-1:0])
        | (gpio_level[GPIO_W-1:0] & gpio_direction[GPIO_W-1:0])};
    else if (reg_addr_in == `A_IOMSK)
      rdata_nxt = gpio_irq_mask;
    else if (reg_addr_in == `A_IOCTL)
      rdata_nxt = io_and_soft_reset_ctrl;
    else if (reg_addr_in == `A_EXTRA_FEATURE_CTRL)
      rdata_nxt = extra_feature_ctrl;
    else if (bank_enh & (reg_addr_in == `A_EFR))
      rdata_nxt = enhanced_feature_ctrl;
    else if (bank_enh & (reg_addr_in == `A_RESUME_CHAR_FIRST))
      rdata_nxt = resume_char_first;
    else if (bank_enh & (reg_addr_in == `A_RESUME_CHAR_SECOND))
      rdata_nxt = resume_char_second;
    else if (bank_enh & (reg_addr_in == `A_PAUSE_CHAR_FIRST))
      rdata_nxt = pause_char_first;
    else if (bank_enh & (reg_addr_in == `A_PAUSE_CHAR_SECOND))
      rdata_nxt = pause_char_second;
    else if (bank_div & (reg_addr_in == `A_DLL))
      rdata_nxt = divisor_low_byte;
    else if (bank_div & (reg_addr_in == `A_DLM))
      rdata_nxt = divisor_high_byte;
    else if (bank_div & (reg_addr_in == `A_DLD))
      rdata_nxt = fraction_and_sampling;
    else if (reg_addr_in == `A_LCR)
      rdata_nxt = line_format_reg;
    else if (bank_enh | (bank_div & (reg_addr_in < `A_MCR)))
      rdata_nxt = `REG_RST;
    else if (reg_addr_in == `A_DATA)
      rdata_nxt = head_valid ? head[7:0] : `REG_RST;
    else if (reg_addr_in == `A_IER)
      rdata_nxt = irq_mask_reg;
    else if (reg_addr_in == `A_ISR)
      rdata_nxt = irq_source_reg;
    else if (reg_addr_in == `A_MCR)
      rdata_nxt = modem_ctrl_reg;
    else if (reg_addr_in == `A_LSR)
      rdata_nxt = line_state_reg;
    else if (reg_addr_in == `A_MSR)
      rdata_nxt = modem_state_in;
    else if (reg_addr_in == `A_SPR)
      rdata_nxt = scratch_r;
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_out <= `REG_RST;
      irq_n_out <= 1'b1;
      tx_wr_out <= 1'b0;
      tx_data_out <= `REG_RST;
      gpio_out <= {GPIO_W{1'b0}};
      gpio_oe_out <= {GPIO_W{1'b0}};
      divisor_out <= 16'h0000;
      fraction_out <= 6'h00;
      rx_disable_out <= 1'b0;
      tx_disable_out <= 1'b0;
      gpio_input_latch <= {GPIO_W{1'b0}};
    end
    else
    begin
      if (reg_rd_in)
        reg_rdata_out <= rdata_nxt;
      irq_n_out <= isr_code[0];
      tx_wr_out <= wr_norm & (reg_addr_in == `A_DATA);
      if (wr_norm & (reg_addr_in == `A_DATA))
        tx_data_out <= reg_wdata_in;
      gpio_out <= gpio_level[GPIO_W-1:0];
      gpio_oe_out <= gpio_direction[GPIO_W-1:0];
      divisor_out <= {divisor_high_byte, divisor_low_byte};
      fraction_out <= enh ? fraction_and_sampling[5:0] : 6'h00;
      rx_disable_out <= extra_feature_ctrl[`EXTRA_FEATURE_CTRL_RXDIS_BIT];
      tx_disable_out <= extra_feature_ctrl[`EXTRA_FEATURE_CTRL_TXDIS_BIT];
      // latched view refreshes when software reads the level register
      if (reg_rd_in & (reg_addr_in == `A_IOLVL))
        gpio_input_latch <= gpio_s2_r;
    end
  end

  // status state, wiped by the soft reset as well
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_r <= 1'b0;
      err_cnt_r <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      overrun_r <= 1'b0;
      err_cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      // a new overrun in the reading cycle wins over the clear
      if (rx_char_valid_in & ~rx_ready_out & ~rx_disable_out)
        overrun_r <= 1'b1;
      else if (reg_rd_in & ~bank_enh & (reg_addr_in == `A_LSR))
        overrun_r <= 1'b0;
      err_cnt_r <= err_cnt_r
        + {{AW{1'b0}}, push_ok & (rx_err_in != 3'b000)}
        - {{AW{1'b0}}, pop & head_valid & (head[10:8] != 3'b000)};
    end
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_mask_reg <= `REG_RST;
      fifo_setup_reg <= `REG_RST;
      line_format_reg <= `LCR_RST;
      modem_ctrl_reg <= `REG_RST;
      scratch_r <= `REG_RST;
      divisor_low_byte <= `REG_RST;
      divisor_high_byte <= `REG_RST;
      fraction_and_sampling <= `REG_RST;
      enhanced_feature_ctrl <= `REG_RST;
      resume_char_first <= `REG_RST;
      resume_char_second <= `REG_RST;
      pause_char_first <= `REG_RST;
      pause_char_second <= `REG_RST;
      gpio_direction <= `REG_RST;
      gpio_level <= `REG_RST;
      gpio_irq_mask <= `REG_RST;
      io_and_soft_reset_ctrl <= `REG_RST;
      extra_feature_ctrl <= `REG_RST;
      soft_reset_out <= 1'b0;
    end
    else if (soft_reset_out)
    begin
      // one cycle pulse; gpio block keeps its setting
      irq_mask_reg <= `REG_RST;
      fifo_setup_reg <= `REG_RST;
      line_format_reg <= `LCR_RST;
      modem_ctrl_reg <= `REG_RST;
      enhanced_feature_ctrl <= `REG_RST;
      extra_feature_ctrl <= `REG_RST;
      soft_reset_out <= 1'b0;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `A_GPIO_DIRECTION)
        gpio_direction <= reg_wdata_in & {{(8-GPIO_W){1'b0}}, {GPIO_W{1'b1}}};
      else if (reg_addr_in == `A_IOLVL)
        gpio_level <= reg_wdata_in & {{(8-GPIO_W){1'b0}}, {GPIO_W{1'b1}}};
      else if (reg_addr_in == `A_IOMSK)
        gpio_irq_mask <= reg_wdata_in & {{(8-GPIO_W){1'b0}}, {GPIO_W{1'b1}}};
      else if (reg_addr_in == `A_IOCTL)
      begin
        io_and_soft_reset_ctrl <= reg_wdata_in & `IOCTL_MASK;
        soft_reset_out <= reg_wdata_in[`IOCTL_SRST_BIT];
      end
      else if (reg_addr_in == `A_EXTRA_FEATURE_CTRL)
        extra_feature_ctrl <= reg_wdata_in & `EXTRA_FEATURE_CTRL_MASK;
      else if (reg_addr_in == `A_LCR)
        line_format_reg <= reg_wdata_in;
      else if (bank_enh)
      begin
        if (reg_addr_in == `A_EFR)
          enhanced_feature_ctrl <= reg_wdata_in;
        else if (reg_addr_in == `A_RESUME_CHAR_FIRST)
          resume_char_first <= reg_wdata_in;
        else if (reg_addr_in == `A_RESUME_CHAR_SECOND)
          resume_char_second <= reg_wdata_in;
        else if (reg_addr_in == `A_PAUSE_CHAR_FIRST)
          pause_char_first <= reg_wdata_in;
        else if (reg_addr_in == `A_PAUSE_CHAR_SECOND)
          pause_char_second <= reg_wdata_in;
      end
      else if (bank_div & (reg_addr_in < `A_MCR))
      begin
        if (reg_addr_in == `A_DLL)
          divisor_low_byte <= reg_wdata_in;
        else if (reg_addr_in == `A_DLM)
          divisor_high_byte <= reg_wdata_in;
        else if ((reg_addr_in == `A_DLD) & enh)
          fraction_and_sampling <= reg_wdata_in;
      end
      else if (reg_addr_in == `A_IER)
        irq_mask_reg <= (reg_wdata_in & `BASE_MASK)
          | (enh ? (reg_wdata_in & `ENH_IER_MASK)
          : (irq_mask_reg & `ENH_IER_MASK));
      else if ((reg_addr_in == `A_ISR) & reg_wdata_in[`FCR_EN_BIT])
        fifo_setup_reg <= (reg_wdata_in & `FCR_SAVE_MASK & ~`ENH_FCR_MASK)
          | (enh ? (reg_wdata_in & `ENH_FCR_MASK)
          : (fifo_setup_reg & `ENH_FCR_MASK));
      else if (reg_addr_in == `A_ISR)
        fifo_setup_reg <= `REG_RST;
      else if (reg_addr_in == `A_MCR)
        modem_ctrl_reg <= (reg_wdata_in & ~`ENH_MCR_MASK)
          | (enh ? (reg_wdata_in & `ENH_MCR_MASK)
          : (modem_ctrl_reg & `ENH_MCR_MASK));
      else if (reg_addr_in == `A_SPR)
        scratch_r <= reg_wdata_in;
    end
  end
endmodule

// ===== uart_regs_assertions.sv
// concurrent checks on the uart register map ports
`timescale 1ns/1ps
module uart_regs_chk (
  input wire clk_in,
  input wire rstn_in,
  input wire [3:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire tx_hold_empty_in,
  input wire tx_shift_empty_in,
  input wire tx_wr_out,
  input wire [7:0] tx_data_out,
  input wire irq_n_out,
  input wire [15:0] divisor_out,
  input wire [5:0] fraction_out,
  input wire rx_disable_out,
  input wire tx_disable_out,
  input wire soft_reset_out
);
  reg [7:0] lcr_r;
  reg efr_r;
  reg [3:0] ier_r;
  // shadow of bank select and enables, seen from the write traffic and the soft reset pulse only
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in || soft_reset_out)
    begin
      lcr_r <= 8'h03;
      efr_r <= 1'b0;
      ier_r <= 4'h0;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == 4'h3)
        lcr_r <= reg_wdata_in;
      if (reg_addr_in == 4'h2 && lcr_r == 8'hbf)
        efr_r <= reg_wdata_in[4];
      if (reg_addr_in == 4'h1 && !lcr_r[7])
        ier_r <= reg_wdata_in[3:0];
    end
  end

  a_tx_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_wr_in && reg_addr_in == 4'h0 && !lcr_r[7]
    |=> tx_wr_out && tx_data_out == $past(reg_wdata_in))
    else $error("holding write gave no transmit pulse");
  a_tx_only: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tx_wr_out |-> $past(reg_wr_in && reg_addr_in == 4'h0 && !lcr_r[7]))
    else $error("transmit pulse without holding write");
  a_div_high: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_wr_in && reg_addr_in == 4'h1 && lcr_r[7] && lcr_r != 8'hbf
    |-> ##2 divisor_out[15:8] == $past(reg_wdata_in, 2))
    else $error("divisor high byte not taken");
  a_frac_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!efr_r) [*3] |-> fraction_out == 6'h00)
    else $error("fraction active without enhanced enable");
  a_lsr_tx: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_rd_in && reg_addr_in == 4'h5 && lcr_r != 8'hbf
    |=> reg_rdata_out[6:5] == {$past(tx_hold_empty_in && tx_shift_empty_in),
    $past(tx_hold_empty_in)})
    else $error("transmit status bits wrong");
  a_rsvd_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_rd_in && reg_addr_in == 4'hd |=> reg_rdata_out == 8'h00)
    else $error("reserved slot read not zero");
  a_soft_once: assert property (@(posedge clk_in) disable iff (!rstn_in)
    soft_reset_out |=> !soft_reset_out)
    else $error("soft reset pulse too long");
  a_soft_cause: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_wr_in && reg_addr_in == 4'he && reg_wdata_in[3] |=> soft_reset_out)
    else $error("soft reset write gave no pulse");
  a_extra_feature_ctrl_out: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_wr_in && reg_addr_in == 4'hf
    |-> ##2 {rx_disable_out, tx_disable_out} ==
    {$past(reg_wdata_in[1], 2), $past(reg_wdata_in[2], 2)})
    else $error("engine disables not taken");
  a_polled: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ier_r == 4'h0) [*3] |-> irq_n_out)
    else $error("interrupt in polled mode");
endmodule

bind uart_regs uart_regs_chk chk_u (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .tx_hold_empty_in(tx_hold_empty_in),
  .tx_shift_empty_in(tx_shift_empty_in),
  .tx_wr_out(tx_wr_out),
  .tx_data_out(tx_data_out),
  .irq_n_out(irq_n_out),
  .divisor_out(divisor_out),
  .fraction_out(fraction_out),
  .rx_disable_out(rx_disable_out),
  .tx_disable_out(tx_disable_out),
  .soft_reset_out(soft_reset_out)
);

// ===== uart_host.sv
// host model driving the decoded register port
`timescale 1ns/1ps
module uart_host (
  input wire logic clk_in,
  output logic [3:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  initial
  begin
    reg_addr_out = 4'h0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= v;
    reg_wr_out <= 1'b1;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    // stale data must not look valid after the strobe
    reg_wdata_out <= ~v;
  endtask
  // software polls status instead of servicing interrupts
  task rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    #1;
    v = reg_rdata_in;
  endtask
endmodule

// ===== tb_uart_regs.sv
// testbench of the uart register map and receive status
`timescale 1ns/1ps
module tb_uart_regs;
  logic clk_in = 0;
  logic rstn_in = 0;
  logic [3:0] addr;
  logic wr, rd;
  logic [7:0] wdata, rdata, txd, d;
  logic [7:0] rxc = 8'h00;
  logic [7:0] modem = 8'h00;
  logic [2:0] rxe = 3'h0;
  logic rxv = 0, hold_e = 1, shift_e = 1;
  logic rx_rdy, tx_wr, irq_n, rxdis, txdis, srst;
  logic [3:0] gpo, gpoe;
  logic [3:0] pins = 4'h9;
  logic [15:0] div;
  logic [5:0] frac;
  int n_fail = 0;
  int checked = 0;
  always #20 clk_in = ~clk_in;
  uart_host host_u (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
  uart_regs dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .rx_char_valid_in(rxv), .rx_char_in(rxc),
    .rx_err_in(rxe), .rx_ready_out(rx_rdy), .tx_hold_empty_in(hold_e),
    .tx_shift_empty_in(shift_e), .tx_wr_out(tx_wr), .tx_data_out(txd),
    .modem_state_in(modem), .gpio_pin_in(pins), .gpio_out(gpo),
    .gpio_oe_out(gpoe), .irq_n_out(irq_n), .divisor_out(div),
    .fraction_out(frac), .rx_disable_out(rxdis), .tx_disable_out(txdis),
    .soft_reset_out(srst));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task test_done;
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task put(input logic [3:0] a, input logic [7:0] v);
    host_u.wr_reg(a, v);
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    host_u.rd_reg(a, d);
    chk(d, e);
  endtask
  task push(input logic [7:0] c, input logic [2:0] e);
    @(posedge clk_in);
    rxv <= 1'b1;
    rxc <= c;
    rxe <= e;
    @(posedge clk_in);
    rxv <= 1'b0;
    rxc <= ~c;
    #1;
  endtask
  task t_reset;
    rdc(4'h3, 8'h03);
    rdc(4'h1, 8'h00);
    rdc(4'h5, 8'h60);
    rdc(4'hd, 8'h00);
    chk(irq_n, 1'b1);
  endtask
  task t_banks;
    put(4'h3, 8'h80);
    put(4'h0, 8'h12);
    put(4'h1, 8'h34);
    put(4'h2, 8'h3f);
    wt(2);
    chk(div, 16'h3412);
    chk(frac, 6'h00);
    rdc(4'h2, 8'h00);
    put(4'h3, 8'hbf);
    put(4'h2, 8'h10);
    put(4'h4, 8'h5a);
    rdc(4'h2, 8'h10);
    rdc(4'h4, 8'h5a);
    put(4'h3, 8'h80);
    put(4'h2, 8'h35);
    wt(2);
    chk(frac, 6'h35);
    rdc(4'h2, 8'h35);
    put(4'h3, 8'h03);
    rdc(4'h4, 8'h00);
    put(4'h1, 8'hf0);
    rdc(4'h1, 8'hf0);
    put(4'h1, 8'h00);
    put(4'h3, 8'hbf);
    put(4'h2, 8'h00);
    put(4'h3, 8'h03);
    put(4'h1, 8'hf0);
    rdc(4'h1, 8'h00);
  endtask
  task t_trig;
    // trigger select 01 means two characters
    put(4'h2, 8'h41);
    put(4'h1, 8'h01);
    push(8'h11, 3'h0);
    wt(2);
    chk(irq_n, 1'b1);
    rdc(4'h5, 8'h61);
    rdc(4'h2, 8'hc1);
    push(8'h22, 3'h0);
    wt(2);
    chk(irq_n, 1'b0);
    rdc(4'h2, 8'hc4);
    rdc(4'h0, 8'h11);
    wt(2);
    chk(irq_n, 1'b1);
    rdc(4'h2, 8'hc1);
    rdc(4'h0, 8'h22);
    rdc(4'h5, 8'h60);
  endtask
  task t_err;
    put(4'h1, 8'h04);
    push(8'h33, 3'h0);
    push(8'h44, 3'h2);
    rdc(4'h5, 8'he1);
    rdc(4'h2, 8'hc6);
    rdc(4'h0, 8'h33);
    rdc(4'h5, 8'he9);
    rdc(4'h0, 8'h44);
    rdc(4'h5, 8'h60);
    wt(2);
    chk(irq_n, 1'b1);
    put(4'h1, 8'h08);
    modem <= 8'h01;
    rdc(4'h2, 8'hc0);
    modem <= 8'h00;
    host_u.rd_reg(4'h6, d);
    put(4'h1, 8'h00);
  endtask
  task t_fill;
    int i;
    for (i = 0; i < 8; i++)
      push(8'(i), 3'h0);
    wt(1);
    chk(rx_rdy, 1'b0);
    chk(irq_n, 1'b1);
    push(8'hee, 3'h0);
    rdc(4'h5, 8'h63);
    rdc(4'h5, 8'h61);
    for (i = 0; i < 8; i++)
      rdc(4'h0, 8'(i));
    rdc(4'h5, 8'h60);
  endtask
  task t_tx;
    hold_e <= 1'b0;
    shift_e <= 1'b0;
    rdc(4'h5, 8'h00);
    shift_e <= 1'b1;
    rdc(4'h5, 8'h00);
    hold_e <= 1'b1;
    shift_e <= 1'b0;
    rdc(4'h5, 8'h20);
    shift_e <= 1'b1;
    rdc(4'h5, 8'h60);
    put(4'h0, 8'ha5);
    wt(1);
    chk(txd, 8'ha5);
  endtask
  task t_ctl;
    put(4'ha, 8'h0f);
    put(4'hb, 8'h05);
    wt(2);
    chk(gpoe, 4'hf);
    chk(gpo, 4'h5);
    put(4'hf, 8'h06);
    wt(1);
    chk({rxdis, txdis}, 2'b11);
    push(8'h55, 3'h0);
    rdc(4'h5, 8'h60);
    put(4'hf, 8'h00);
    put(4'h3, 8'h1b);
    put(4'he, 8'h08);
    wt(3);
    rdc(4'h3, 8'h03);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    wt(3);
    t_reset;
    t_banks;
    t_trig;
    t_err;
    t_fill;
    t_tx;
    t_ctl;
    test_done;
  end
endmodule
